/* fdc_drv_pkg.sv */
package fdc_drv_pkg;

    localparam int ADDR_W = 12;
    localparam int IDX_W = 10;
    localparam int DATA_W = 32;

    // register indices; byte address is four times the index
    localparam logic [IDX_W-1:0] DOR_IDX = 10'h3F2;
    localparam logic [IDX_W-1:0] TAPE_IDX = 10'h3F3;

    // drive_output_control fields
    localparam int DRV_SEL_LSB = 0;
    localparam int SWRST_BIT = 2;
    localparam int DMAEN_BIT = 3;
    localparam int MOTOR_LSB = 4;
    localparam int MOTOR_W = 4;
    localparam logic [7:0] DOR_RESET = 8'h00;

    // tape_drive_select fields
    localparam int TAPE_W = 2;
    localparam logic [TAPE_W-1:0] TAPE_RESET = 2'h0;
    localparam logic [3:0] TAPE_NONE_HOT = 4'h1;

    // read byte lanes actually driven
    localparam logic [7:0] LANES_ALL = 8'hFF;
    localparam logic [7:0] LANES_TAPE = 8'h03;

    localparam logic [1:0] DRV0 = 2'h0;
    localparam logic [1:0] DRV1 = 2'h1;
    localparam logic [3:0] PICK_IDLE = 4'hF;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic HRESP_OKAY = 1'b0;

    function automatic logic [ADDR_W-1:0] regByte(logic [IDX_W-1:0] idx);
        return {idx, 2'b00};
    endfunction

    function automatic logic motorOf(logic [7:0] d, logic [1:0] n);
        return d[MOTOR_LSB + int'(n)];
    endfunction

    // drives 0 and 1 trade places when swapped
    function automatic logic [1:0] physDrive(logic [1:0] n, logic swap);
        return (swap && (n == DRV0 || n == DRV1)) ? (n ^ DRV1) : n;
    endfunction

endpackage

/* drive_pick_decode.sv */
`timescale 1ns/10ps
`default_nettype none
module drive_pick_decode import fdc_drv_pkg::*; (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [7:0] drive_output_control,
    input wire logic extDecode,
    input wire logic swapDrives,
    output logic [3:0] drvPickN,
    output logic [3:0] spindleOnN
);
    logic [3:0] next_drvPickN;
    logic [3:0] next_spindleOnN;
    logic [1:0] sel;
    logic [3:0] motors;
    logic selOn;
    logic [1:0] phys;

    always_comb begin
        sel = drive_output_control[DRV_SEL_LSB +: 2];
        motors = drive_output_control[MOTOR_LSB +: MOTOR_W];
        selOn = motorOf(drive_output_control, sel);
        phys = physDrive(sel, swapDrives);
        next_drvPickN = PICK_IDLE;
        next_spindleOnN = PICK_IDLE;
        if (!extDecode) begin
            if (selOn) begin
                next_drvPickN[phys] = 1'b0;
            end
            next_spindleOnN = ~motors;
            if (swapDrives) begin
                next_spindleOnN[0] = ~motors[1];
                next_spindleOnN[1] = ~motors[0];
            end
        end else begin
            next_drvPickN[1:0] = phys;
            next_spindleOnN[0] = ~selOn;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            drvPickN <= PICK_IDLE;
            spindleOnN <= PICK_IDLE;
        end else begin
            drvPickN <= next_drvPickN;
            spindleOnN <= next_spindleOnN;
        end
    end

    property p_int_sel;
        @(posedge clk) disable iff (!rst_n)
        (!extDecode && !swapDrives && motorOf(drive_output_control, drive_output_control[1:0]))
            |=> drvPickN == ~(4'h1 << $past(drive_output_control[1:0]));
    endproperty
    a_int_sel: assert property (p_int_sel)
        else $error("internal select wrong");

    property p_int_idle;
        @(posedge clk) disable iff (!rst_n)
        (!extDecode && drive_output_control[MOTOR_LSB +: MOTOR_W] == 4'h0)
            |=> drvPickN == PICK_IDLE;
    endproperty
    a_int_idle: assert property (p_int_idle)
        else $error("select active with motors off");

    property p_int_motor;
        @(posedge clk) disable iff (!rst_n)
        (!extDecode && !swapDrives)
            |=> spindleOnN == ~$past(drive_output_control[MOTOR_LSB +: MOTOR_W]);
    endproperty
    a_int_motor: assert property (p_int_motor)
        else $error("motor outputs wrong");

    property p_swap_int;
        @(posedge clk) disable iff (!rst_n)
        (!extDecode && swapDrives && drive_output_control[1:0] == DRV0 && drive_output_control[MOTOR_LSB])
            |=> drvPickN == 4'hD && spindleOnN[1] == 1'b0;
    endproperty
    a_swap_int: assert property (p_swap_int)
        else $error("swapped internal decode wrong");

    property p_ext_plain;
        @(posedge clk) disable iff (!rst_n)
        (extDecode && !swapDrives)
            |=> drvPickN[1:0] == $past(drive_output_control[1:0]) && spindleOnN[1];
    endproperty
    a_ext_plain: assert property (p_ext_plain)
        else $error("external code wrong");

    property p_ext_motor;
        @(posedge clk) disable iff (!rst_n)
        extDecode |=> spindleOnN[0] == !$past(motorOf(drive_output_control, drive_output_control[1:0]));
    endproperty
    a_ext_motor: assert property (p_ext_motor)
        else $error("external motor line wrong");

    property p_ext_swap;
        @(posedge clk) disable iff (!rst_n)
        (extDecode && swapDrives && drive_output_control[1:0] == DRV0)
            |=> drvPickN[1:0] == DRV1;
    endproperty
    a_ext_swap: assert property (p_ext_swap)
        else $error("swapped external code wrong");

    property p_ext_upper;
        @(posedge clk) disable iff (!rst_n)
        extDecode |=> drvPickN[3:2] == 2'b11 && spindleOnN[3:2] == 2'b11;
    endproperty
    a_ext_upper: assert property (p_ext_upper)
        else $error("unused lines active in external mode");
endmodule // drive_pick_decode
`default_nettype wire

/* tape_select_reg.sv */
`timescale 1ns/10ps
`default_nettype none
module tape_select_reg import fdc_drv_pkg::*; (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic wrEn,
    input wire logic [TAPE_W-1:0] wrData,
    output logic [TAPE_W-1:0] tapeBits,
    output logic [3:0] tapeOneHot
);
    logic [TAPE_W-1:0] next_tapeBits;
    logic [3:0] next_tapeOneHot;

    // only the hard reset clears it
    always_comb begin
        next_tapeBits = wrEn ? wrData : tapeBits;
        next_tapeOneHot = TAPE_NONE_HOT << next_tapeBits;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tapeBits <= TAPE_RESET;
            tapeOneHot <= TAPE_NONE_HOT;
        end else begin
            tapeBits <= next_tapeBits;
            tapeOneHot <= next_tapeOneHot;
        end
    end

    property p_tape_map;
        @(posedge clk) disable iff (!rst_n)
        wrEn |=> tapeOneHot == (TAPE_NONE_HOT << $past(wrData));
    endproperty
    a_tape_map: assert property (p_tape_map)
        else $error("tape selection decode wrong");
endmodule // tape_select_reg
`default_nettype wire

/* drive_select_motor_decode.sv */
`timescale 1ns/10ps
`default_nettype none
// Functional notes
// - tape register is host read/write and steers nothing inside
// - tape register keeps its value through a controller software reset
// - tape register read drives bits 1:0 only; lanes 7:2 undriven
// - tape bits 00 none, 01 drive 1, 10 drive 2, 11 drive 3
// - internal plain decode: selected drive picked only if its motor on
// - internal plain: motor lines follow bits 4..7; all off, no select
// - internal swapped: drives 0 and 1 trade select and motor lines
// - external plain: code on two lines, motor0 from selected enable
// - external swapped: drive 0 gives 01, drive 1 gives 00
// - drive number from control bits 1:0, motor enables bits 7:4
module drive_select_motor_decode import fdc_drv_pkg::*; (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic hsel,
    input wire logic [ADDR_W-1:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [DATA_W-1:0] hwdata,
    input wire logic hready,
    output logic [DATA_W-1:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    output logic [7:0] laneEn,
    input wire logic extDecode,
    input wire logic swapDrives,
    output logic drvPickN0,
    output logic drvPickN1,
    output logic drvPickN2,
    output logic drvPickN3,
    output logic spindleOnN0,
    output logic spindleOnN1,
    output logic spindleOnN2,
    output logic spindleOnN3,
    output logic tapePickHi,
    output logic tapePickLo,
    output logic [3:0] tapeOneHot,
    output logic fdcResetN,
    output logic dmaEnable
);
    logic [7:0] drive_output_control;
    logic [7:0] next_dor;
    logic dataActive;
    logic next_dataActive;
    logic dataWrite;
    logic next_dataWrite;
    logic [ADDR_W-1:0] dataAddr;
    logic [ADDR_W-1:0] next_dataAddr;
    logic [DATA_W-1:0] next_hrdata;
    logic [7:0] next_laneEn;
    logic accept;
    logic dorWrite;
    logic tapeWrite;
    logic [TAPE_W-1:0] tapeBits;
    logic [TAPE_W-1:0] tapeNow;
    logic [3:0] drvPickN;
    logic [3:0] spindleOnN;

    // address phase capture and data phase write strobes
    always_comb begin
        accept = hsel && htrans == HTRANS_NONSEQ && hready;
        next_dataActive = accept;
        next_dataWrite = accept && hwrite;
        next_dataAddr = accept ? haddr : dataAddr;
        dorWrite = dataActive && dataWrite
            && dataAddr == regByte(DOR_IDX);
        tapeWrite = dataActive && dataWrite
            && dataAddr == regByte(TAPE_IDX);
        next_dor = dorWrite ? hwdata[7:0] : drive_output_control;
        tapeNow = tapeWrite ? hwdata[TAPE_W-1:0] : tapeBits;
    end

    // read data forwarded from any write finishing this cycle
    always_comb begin
        next_hrdata = hrdata;
        next_laneEn = laneEn;
        if (accept && !hwrite) begin
            if (haddr == regByte(DOR_IDX)) begin
                next_hrdata = {24'h000000, next_dor};
                next_laneEn = LANES_ALL;
            end else if (haddr == regByte(TAPE_IDX)) begin
                next_hrdata = {{(DATA_W-TAPE_W){1'b0}}, tapeNow};
                next_laneEn = LANES_TAPE;
            end else begin
                next_hrdata = 32'h00000000;
                next_laneEn = LANES_ALL;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            drive_output_control <= DOR_RESET;
            dataActive <= 1'b0;
            dataWrite <= 1'b0;
            dataAddr <= '0;
            hrdata <= '0;
            laneEn <= LANES_ALL;
            hreadyout <= 1'b1;
            hresp <= HRESP_OKAY;
        end else begin
            drive_output_control <= next_dor;
            dataActive <= next_dataActive;
            dataWrite <= next_dataWrite;
            dataAddr <= next_dataAddr;
            hrdata <= next_hrdata;
            laneEn <= next_laneEn;
            hreadyout <= 1'b1;
            hresp <= HRESP_OKAY;
        end
    end

    assign fdcResetN = drive_output_control[SWRST_BIT];
    assign dmaEnable = drive_output_control[DMAEN_BIT];

    tape_select_reg tapeReg (
        .clk(clk),
        .rst_n(rst_n),
        .wrEn(tapeWrite),
        .wrData(hwdata[TAPE_W-1:0]),
        .tapeBits(tapeBits),
        .tapeOneHot(tapeOneHot)
    );

    assign tapePickHi = tapeBits[1];
    assign tapePickLo = tapeBits[0];

    drive_pick_decode decoder (
        .clk(clk),
        .rst_n(rst_n),
        .drive_output_control(drive_output_control),
        .extDecode(extDecode),
        .swapDrives(swapDrives),
        .drvPickN(drvPickN),
        .spindleOnN(spindleOnN)
    );

    assign drvPickN0 = drvPickN[0];
    assign drvPickN1 = drvPickN[1];
    assign drvPickN2 = drvPickN[2];
    assign drvPickN3 = drvPickN[3];
    assign spindleOnN0 = spindleOnN[0];
    assign spindleOnN1 = spindleOnN[1];
    assign spindleOnN2 = spindleOnN[2];
    assign spindleOnN3 = spindleOnN[3];

    property p_dor_write;
        @(posedge clk) disable iff (!rst_n)
        dorWrite |=> drive_output_control == $past(hwdata[7:0]);
    endproperty
    a_dor_write: assert property (p_dor_write)
        else $error("control register write lost");

    property p_dor_hold;
        @(posedge clk) disable iff (!rst_n)
        !dorWrite |=> $stable(drive_output_control);
    endproperty
    a_dor_hold: assert property (p_dor_hold)
        else $error("control register changed without write");

    property p_tape_write;
        @(posedge clk) disable iff (!rst_n)
        tapeWrite |=> {tapePickHi, tapePickLo} == $past(hwdata[1:0]);
    endproperty
    a_tape_write: assert property (p_tape_write)
        else $error("tape register write lost");

    property p_tape_soft;
        @(posedge clk) disable iff (!rst_n)
        (!fdcResetN && !tapeWrite) |=> $stable(tapeBits);
    endproperty
    a_tape_soft: assert property (p_tape_soft)
        else $error("tape register disturbed in software reset");

    property p_tape_read;
        @(posedge clk) disable iff (!rst_n)
        (accept && !hwrite && haddr == regByte(TAPE_IDX))
            |=> laneEn == LANES_TAPE && hrdata[DATA_W-1:TAPE_W] == '0
                && hrdata[TAPE_W-1:0] == tapeBits;
    endproperty
    a_tape_read: assert property (p_tape_read)
        else $error("tape read lanes wrong");

    property p_dor_read;
        @(posedge clk) disable iff (!rst_n)
        (accept && !hwrite && haddr == regByte(DOR_IDX))
            |=> hrdata[7:0] == drive_output_control && laneEn == LANES_ALL;
    endproperty
    a_dor_read: assert property (p_dor_read)
        else $error("control register read wrong");

    property p_no_wait;
        @(posedge clk) disable iff (!rst_n)
        accept |=> hreadyout && hresp == HRESP_OKAY;
    endproperty
    a_no_wait: assert property (p_no_wait)
        else $error("slave inserted a wait or error");

    property p_rdata_hold;
        @(posedge clk) disable iff (!rst_n)
        !(accept && !hwrite) |=> $stable(hrdata);
    endproperty
    a_rdata_hold: assert property (p_rdata_hold)
        else $error("read data moved without a read");

    property p_lane_hold;
        @(posedge clk) disable iff (!rst_n)
        !(accept && !hwrite) |=> $stable(laneEn);
    endproperty
    a_lane_hold: assert property (p_lane_hold)
        else $error("driven lanes moved without a read");

    property p_unmapped_read;
        @(posedge clk) disable iff (!rst_n)
        (accept && !hwrite && haddr != regByte(DOR_IDX)
            && haddr != regByte(TAPE_IDX))
            |=> hrdata == '0 && laneEn == LANES_ALL;
    endproperty
    a_unmapped_read: assert property (p_unmapped_read)
        else $error("unmapped read not zero");

    property p_ctl_bits;
        @(posedge clk) disable iff (!rst_n)
        dorWrite |=> fdcResetN == $past(hwdata[SWRST_BIT])
            && dmaEnable == $past(hwdata[DMAEN_BIT]);
    endproperty
    a_ctl_bits: assert property (p_ctl_bits)
        else $error("reset or dma bit not taken");

    property p_dor_forward;
        @(posedge clk) disable iff (!rst_n)
        (dorWrite && accept && !hwrite && haddr == regByte(DOR_IDX))
            |=> hrdata[7:0] == $past(hwdata[7:0]);
    endproperty
    a_dor_forward: assert property (p_dor_forward)
        else $error("read after write missed new control value");

    property p_tape_forward;
        @(posedge clk) disable iff (!rst_n)
        (tapeWrite && accept && !hwrite && haddr == regByte(TAPE_IDX))
            |=> hrdata[TAPE_W-1:0] == $past(hwdata[TAPE_W-1:0]);
    endproperty
    a_tape_forward: assert property (p_tape_forward)
        else $error("read after write missed new tape value");

    property p_tape_hold;
        @(posedge clk) disable iff (!rst_n)
        !tapeWrite |=> $stable({tapePickHi, tapePickLo});
    endproperty
    a_tape_hold: assert property (p_tape_hold)
        else $error("tape bits changed without a write");

    property p_tape_no_effect;
        @(posedge clk) disable iff (!rst_n)
        tapeWrite |=> $stable(drive_output_control);
    endproperty
    a_tape_no_effect: assert property (p_tape_no_effect)
        else $error("tape write disturbed control register");

    property p_tape_hot;
        @(posedge clk) disable iff (!rst_n)
        $onehot(tapeOneHot)
            && tapeOneHot == (TAPE_NONE_HOT << {tapePickHi, tapePickLo});
    endproperty
    a_tape_hot: assert property (p_tape_hot)
        else $error("tape one-hot does not match tape bits");

    property p_pick_single;
        @(posedge clk) disable iff (!rst_n)
        !extDecode |=> $countones(~drvPickN) <= 1;
    endproperty
    a_pick_single: assert property (p_pick_single)
        else $error("more than one drive selected");

    property p_ext_motor_hi;
        @(posedge clk) disable iff (!rst_n)
        extDecode |=> {spindleOnN3, spindleOnN2, spindleOnN1} == 3'b111;
    endproperty
    a_ext_motor_hi: assert property (p_ext_motor_hi)
        else $error("spare motor lines active in external mode");

    property p_swap_motor;
        @(posedge clk) disable iff (!rst_n)
        (!extDecode && swapDrives)
            |=> spindleOnN0 == !$past(drive_output_control[MOTOR_LSB + 1])
                && spindleOnN1 == !$past(drive_output_control[MOTOR_LSB]);
    endproperty
    a_swap_motor: assert property (p_swap_motor)
        else $error("swapped motor lines wrong");

    property p_int_upper;
        @(posedge clk) disable iff (!rst_n)
        !extDecode
            |=> spindleOnN2 == !$past(drive_output_control[MOTOR_LSB + 2])
                && spindleOnN3 == !$past(drive_output_control[MOTOR_LSB + 3]);
    endproperty
    a_int_upper: assert property (p_int_upper)
        else $error("motor lines of drives 2 and 3 wrong");

    property p_bus_okay;
        @(posedge clk) disable iff (!rst_n)
        hreadyout && hresp == HRESP_OKAY;
    endproperty
    a_bus_okay: assert property (p_bus_okay)
        else $error("slave not ready or not okay");
endmodule // drive_select_motor_decode
`default_nettype wire

/* floppy_drives.sv */
`timescale 1ns/10ps
`default_nettype none
module floppy_drives (
    input wire logic extDecode,
    input wire logic [3:0] pickN,
    output logic [2:0] pickCount
);
    // drives only listen; count how many see their select low while extDecode is low
    always_comb begin
        pickCount = 3'h0;
        for (int i = 0; i < 4; i++) begin
            pickCount = pickCount + 3'(~pickN[i] & ~extDecode);
        end
    end
endmodule // floppy_drives
`default_nettype wire

/* testbench.sv */
`timescale 1ns/10ps
`default_nettype none
module testbench import fdc_drv_pkg::*;;
    logic clk = 1'b0, rst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic extDecode = 1'b0, swapDrives = 1'b0;
    logic [11:0] haddr = 12'h000;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0, hrdata;
    logic hreadyout, hresp, tapePickHi, tapePickLo, fdcResetN, dmaEnable;
    logic [7:0] laneEn;
    logic [3:0] tapeOneHot;
    wire logic [3:0] pickN, spinN;
    logic [2:0] pickCount;
    int err_total = 0, cmp_count = 0, cyc = 0;
    localparam logic [11:0] DOR_A = {DOR_IDX, 2'b00};
    localparam logic [11:0] TAPE_A = {TAPE_IDX, 2'b00};
    always #5 clk = ~clk;
    drive_select_motor_decode dut (.clk(clk), .rst_n(rst_n), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .laneEn(laneEn),
        .extDecode(extDecode), .swapDrives(swapDrives),
        .drvPickN0(pickN[0]), .drvPickN1(pickN[1]), .drvPickN2(pickN[2]),
        .drvPickN3(pickN[3]), .spindleOnN0(spinN[0]),
        .spindleOnN1(spinN[1]), .spindleOnN2(spinN[2]),
        .spindleOnN3(spinN[3]), .tapePickHi(tapePickHi),
        .tapePickLo(tapePickLo), .tapeOneHot(tapeOneHot),
        .fdcResetN(fdcResetN), .dmaEnable(dmaEnable));
    floppy_drives drives (.extDecode(extDecode), .pickN(pickN),
        .pickCount(pickCount));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp,
            input string m);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("FAIL %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask
    task automatic bus(input logic w, input logic [11:0] a,
            input logic [31:0] d, output logic [31:0] r);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        htrans <= HTRANS_NONSEQ;
        do @(posedge clk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hreadyout !== 1'b1);
        r = hrdata;
    endtask
    // expected select and motor lines from the decode tables
    function automatic logic [7:0] expOut(logic [7:0] d, logic ext,
            logic sw);
        logic [1:0] drv;
        logic [1:0] phys;
        logic [3:0] en;
        logic [3:0] pick;
        logic [3:0] mot;
        drv = d[1:0];
        en = d[7:4];
        phys = (sw && !drv[1]) ? {1'b0, ~drv[0]} : drv;
        if (ext) begin
            pick = {2'b11, phys};
            mot = {3'b111, ~en[drv]};
        end else begin
            pick = en[drv] ? ~(4'h1 << phys) : 4'hF;
            mot = sw ? {~en[3:2], ~en[0], ~en[1]} : ~en;
        end
        return {pick, mot};
    endfunction
    task automatic t_reset;
        chk({pickN, spinN}, 8'hFF, "reset lines");
        chk({tapeOneHot, tapePickHi, tapePickLo}, 6'h04, "reset tape");
        chk({laneEn, hresp, fdcResetN, dmaEnable}, 11'h7F8, "reset bus");
        $display("test reset done");
    endtask
    task automatic t_tape;
        logic [31:0] r;
        logic [7:0] keep;
        keep = {pickN, spinN};
        for (int v = 0; v < 4; v++) begin
            bus(1'b1, TAPE_A, 32'hFFFFFFFC | v, r);
            bus(1'b0, TAPE_A, 32'h0, r);
            chk(r, v, "tape read");
            chk(laneEn, 8'h03, "tape lanes");
            chk(tapeOneHot, 4'h1 << v, "tape decode");
            chk({tapePickHi, tapePickLo}, v, "tape pins");
            chk({pickN, spinN}, keep, "tape no effect");
        end
        bus(1'b1, DOR_A, 32'h0, r);
        bus(1'b1, DOR_A, 32'h4, r);
        bus(1'b0, TAPE_A, 32'h0, r);
        chk(r, 32'h3, "tape after soft reset");
        bus(1'b0, DOR_A, 32'h0, r);
        chk({laneEn, r}, {8'hFF, 32'h4}, "control read");
        $display("test tape done");
    endtask
    task automatic t_decode(input logic ext, input logic sw);
        logic [31:0] r;
        logic [7:0] d;
        extDecode <= ext;
        swapDrives <= sw;
        for (int v = 0; v < 256; v++) begin
            d = 8'(v);
            bus(1'b1, DOR_A, {24'hFFFFFF, d}, r);
            repeat (2) @(posedge clk);
            chk({pickN, spinN}, expOut(d, ext, sw), "decode");
            chk(pickCount, (!ext && d[4 + d[1:0]]) ? 1 : 0, "one");
            chk({fdcResetN, dmaEnable}, {d[2], d[3]}, "ctl bits");
            bus(1'b0, DOR_A, 32'h0, r);
            chk(r, d, "control readback");
        end
        $display("test decode ext %0d swap %0d done", ext, sw);
    endtask
    task automatic t_unmapped;
        logic [31:0] r;
        bus(1'b1, 12'h000, 32'hFF, r);
        bus(1'b0, 12'h000, 32'h0, r);
        chk({laneEn, r}, {8'hFF, 32'h0}, "unmapped read");
        chk({hreadyout, hresp}, 2'h2, "bus response");
        bus(1'b0, TAPE_A, 32'h0, r);
        chk(r, 32'h3, "unmapped write ignored");
        $display("test unmapped done");
    endtask
    task automatic close_out;
        $display("comparisons %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            err_total++;
            close_out();
        end
    end
    initial begin
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        t_reset();
        t_tape();
        t_decode(1'b0, 1'b0);
        t_decode(1'b0, 1'b1);
        t_decode(1'b1, 1'b0);
        t_decode(1'b1, 1'b1);
        t_unmapped();
        close_out();
    end
endmodule // testbench
`default_nettype wire
